//--- zq_pkg.sv
// shared constants, command codes and timing counts for the zq calibration ends
// assumes a single 25 MHz clock on both ends; the command link is cycle synchronous
package zq_pkg;

  // clock period and precharge time, both in picoseconds
  localparam int TCK_PS = 40000;
  localparam int TRP_PS = 13500;
  // least time, rounded up to whole cycles, never below one
  localparam int TRP_RAW = (TRP_PS + TCK_PS - 1) / TCK_PS;
  localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;

  // calibration windows in clock cycles
  localparam int TZQINIT_NCK = 512;
  localparam int TZQOPER_NCK = 256;
  localparam int TZQCS_NCK = 64;
  // a short calibration must finish its correction within this many cycles
  localparam int ZQCS_CORR_NCK = 64;
  // self refresh exit time in cycles
  localparam int TXS_NCK = 8;

  // counter width for the longest window
  localparam int CNT_W = 10;

  // impedance code layout
  localparam int CODE_W = 6;
  localparam logic [CODE_W-1:0] CODE_MID = 6'h20;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
  localparam logic [CODE_W-1:0] CODE_MIN = 6'h00;

  // commands on the link
  typedef enum logic [2:0] {
    CMD_NOP  = 3'h0,
    CMD_PREA = 3'h1,
    CMD_ZQCL = 3'h2,
    CMD_ZQCS = 3'h3,
    CMD_SRE  = 3'h4,
    CMD_SRX  = 3'h5
  } cmd_e;

endpackage

//--- zq_link_if.sv
// command link between memory controller and memory device
// assumes both ends share clock; the controller alone drives the link
`timescale 1ns/1ps
interface zq_link_if;
  logic         cke;    // clock enable, high when the device is awake
  zq_pkg::cmd_e cmd;    // command for one cycle
  logic         odt;    // termination control
  logic         dq_oe;  // controller drives the data bus

  modport ctrl (output cke, output cmd, output odt, output dq_oe);
  modport dev  (input cke, input cmd, input odt, input dq_oe);
endinterface

//--- zq_device.sv
// device end: zq calibration engine and impedance code transfer to io
// assumes the link is driven synchronously to clock by a controller end
`timescale 1ns/1ps
module zq_device #(
  parameter int TZQINIT = zq_pkg::TZQINIT_NCK,
  parameter int TZQOPER = zq_pkg::TZQOPER_NCK,
  parameter int TZQCS   = zq_pkg::TZQCS_NCK
) (
  input  wire logic                      clock,          // system clock
  input  wire logic                      nrst,           // async reset, active low
  zq_link_if.dev                         link,           // command link
  input  wire logic                      zq_cmp_high,    // pad below target, raise code
  output logic [zq_pkg::CODE_W-1:0]      ron_code,       // driver strength in io
  output logic [zq_pkg::CODE_W-1:0]      rtt_code,       // termination value in io
  output logic                           zq_current_en,  // calibration current path on
  output logic                           calibrating,    // engine running
  output logic                           cal_done,       // pulse at value transfer
  output logic                           in_self_refresh // device in self refresh
);

  // refuse windows the counter cannot hold or a short window past its bound
  if (TZQINIT >= (1 << zq_pkg::CNT_W) || TZQOPER >= (1 << zq_pkg::CNT_W) ||
      TZQCS > zq_pkg::ZQCS_CORR_NCK || TZQCS < 2 || TZQOPER < 2) begin : g_chk
    $error("zq_device: unsupported window length");
  end

  localparam logic [zq_pkg::CNT_W-1:0] WIN_INIT = zq_pkg::CNT_W'(TZQINIT);
  localparam logic [zq_pkg::CNT_W-1:0] WIN_OPER = zq_pkg::CNT_W'(TZQOPER);
  localparam logic [zq_pkg::CNT_W-1:0] WIN_CS   = zq_pkg::CNT_W'(TZQCS);

  logic                        long_seen_reg;
  logic [zq_pkg::CNT_W-1:0]    cnt_reg;
  logic [zq_pkg::CODE_W-1:0]   trial_reg;
  logic                        zql_cmd;
  logic                        zqs_cmd;

  // commands count only while cke is registered high
  assign zql_cmd = link.cke && (link.cmd == zq_pkg::CMD_ZQCL);
  assign zqs_cmd = link.cke && (link.cmd == zq_pkg::CMD_ZQCS);

  // remembers whether a long calibration has happened since reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      long_seen_reg <= 1'b0;
    end else if (zql_cmd) begin
      long_seen_reg <= 1'b1;
    end
  end

  // window counter: first long gets init, later long gets oper, short gets cs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (zql_cmd) begin
      cnt_reg <= long_seen_reg ? WIN_OPER : WIN_INIT;
    end else if (zqs_cmd) begin
      cnt_reg <= WIN_CS;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // code tracks the comparator one step per cycle; long restarts from mid scale
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trial_reg <= zq_pkg::CODE_MID;
    end else if (zql_cmd) begin
      trial_reg <= zq_pkg::CODE_MID;
    end else if (cnt_reg > 1) begin
      if (zq_cmp_high && trial_reg != zq_pkg::CODE_MAX) begin
        trial_reg <= trial_reg + 1'b1;
      end else if (!zq_cmp_high && trial_reg != zq_pkg::CODE_MIN) begin
        trial_reg <= trial_reg - 1'b1;
      end
    end
  end

  // transfer result to io on the last cycle of the window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ron_code <= zq_pkg::CODE_MID;
      rtt_code <= zq_pkg::CODE_MID;
      cal_done <= 1'b0;
    end else begin
      cal_done <= 1'b0;
      if (cnt_reg == 1 && !zql_cmd && !zqs_cmd) begin
        ron_code <= trial_reg;
        rtt_code <= trial_reg;
        cal_done <= 1'b1;
      end
    end
  end

  // current path only while a window is open, off once values are in io
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      zq_current_en <= 1'b0;
      calibrating   <= 1'b0;
    end else begin
      zq_current_en <= zql_cmd || zqs_cmd || cnt_reg > 1;
      calibrating   <= zql_cmd || zqs_cmd || cnt_reg > 1;
    end
  end

  // self refresh tracking; exit starts no calibration by itself
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_self_refresh <= 1'b0;
    end else if (link.cmd == zq_pkg::CMD_SRE) begin
      in_self_refresh <= 1'b1;
    end else if (link.cmd == zq_pkg::CMD_SRX) begin
      in_self_refresh <= 1'b0;
    end
  end

endmodule

//--- zq_controller.sv
// controller end: schedules precharge, self refresh exit and zq commands
// assumes a user scheduler raises request pulses and reports open banks
`timescale 1ns/1ps
module zq_controller #(
  parameter int TZQINIT = zq_pkg::TZQINIT_NCK,
  parameter int TZQOPER = zq_pkg::TZQOPER_NCK,
  parameter int TZQCS   = zq_pkg::TZQCS_NCK,
  parameter int TXS     = zq_pkg::TXS_NCK,
  parameter int TRP     = zq_pkg::TRP_CYC
) (
  input  wire logic  clock,        // system clock
  input  wire logic  nrst,         // async reset, active low
  zq_link_if.ctrl    link,         // command link
  input  wire logic  zqcl_req,     // pulse: request long calibration
  input  wire logic  zqcs_req,     // pulse: request short calibration
  input  wire logic  sre_req,      // pulse: enter self refresh
  input  wire logic  srx_req,      // pulse: leave self refresh
  input  wire logic  banks_open,   // level: some bank is open
  input  wire logic  share_busy,   // level: a peer on the resistor calibrates
  input  wire logic  odt_req,      // level: wanted termination state
  input  wire logic  dq_drive_req, // level: wanted data drive
  output logic       cal_active,   // level: own window in progress
  output logic       busy,         // level: not idle
  output logic       long_done     // level: a long calibration issued since reset
);

  // refuse counts the counter cannot hold, except an oversized short window
  if (TZQINIT >= (1 << zq_pkg::CNT_W) || TZQOPER >= (1 << zq_pkg::CNT_W) ||
      TZQCS < 1 || TXS < 1 || TRP < 1 || TXS >= (1 << zq_pkg::CNT_W) ||
      TRP >= (1 << zq_pkg::CNT_W)) begin : g_chk
    $error("zq_controller: unsupported timing count");
  end

  localparam logic [zq_pkg::CNT_W-1:0] WIN_INIT = zq_pkg::CNT_W'(TZQINIT);
  localparam logic [zq_pkg::CNT_W-1:0] WIN_OPER = zq_pkg::CNT_W'(TZQOPER);
  localparam logic [zq_pkg::CNT_W-1:0] WIN_CS   = zq_pkg::CNT_W'(TZQCS);
  localparam logic [zq_pkg::CNT_W-1:0] XS_CNT   = zq_pkg::CNT_W'(TXS);
  localparam logic [zq_pkg::CNT_W-1:0] RP_CNT   = zq_pkg::CNT_W'(TRP);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_PRE   = 7'h02,
    ST_TRP   = 7'h04,
    ST_ISSUE = 7'h08,
    ST_WAIT  = 7'h10,
    ST_SREF  = 7'h20,
    ST_XS    = 7'h40
  } state_e;

  state_e                     state_reg;
  state_e                     state_next;
  logic [zq_pkg::CNT_W-1:0]   cnt_reg;
  logic                       pend_long_reg;
  logic                       pend_short_reg;
  logic                       issue_long;
  logic                       cnt_zero;
  logic                       quiet;

  assign cnt_zero   = (cnt_reg == '0);
  // kind actually put on the link, so a long request landing at issue stays pending
  assign issue_long = (link.cmd == zq_pkg::CMD_ZQCL);
  // quiet covers preparation and window alike
  assign quiet      = (state_reg == ST_PRE) || (state_reg == ST_TRP) ||
                      (state_reg == ST_ISSUE) || (state_reg == ST_WAIT);

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sre_req) begin
          state_next = ST_SREF;
        end else if ((pend_long_reg || pend_short_reg) && !share_busy) begin
          state_next = banks_open ? ST_PRE : ST_ISSUE;
        end
      end
      ST_PRE: begin
        state_next = ST_TRP;
      end
      ST_TRP: begin
        if (cnt_zero) begin
          state_next = share_busy ? ST_IDLE : ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (cnt_zero) begin
          state_next = ST_IDLE;
        end
      end
      ST_SREF: begin
        if (srx_req) begin
          state_next = ST_XS;
        end
      end
      ST_XS: begin
        if (cnt_zero) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // shared down counter for tRP, tXS and calibration windows
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_PRE) begin
      cnt_reg <= RP_CNT - 1'b1;
    end else if (state_reg == ST_SREF && srx_req) begin
      cnt_reg <= XS_CNT - 1'b1;
    end else if (state_reg == ST_ISSUE) begin
      if (issue_long) begin
        cnt_reg <= long_done ? WIN_OPER - 1'b1 : WIN_INIT - 1'b1;
      end else begin
        cnt_reg <= WIN_CS - 1'b1;
      end
    end else if (!cnt_zero) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // pending requests; a new request wins over the clear at issue
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pend_long_reg  <= 1'b0;
      pend_short_reg <= 1'b0;
    end else begin
      pend_long_reg  <= zqcl_req ||
                        (pend_long_reg && !(state_reg == ST_ISSUE && issue_long));
      pend_short_reg <= zqcs_req ||
                        (pend_short_reg && !(state_reg == ST_ISSUE && !issue_long));
    end
  end

  // record of a long calibration since reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      long_done <= 1'b0;
    end else if (state_reg == ST_ISSUE && issue_long) begin
      long_done <= 1'b1;
    end
  end

  // command output, one cycle per command, nop otherwise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link.cmd <= zq_pkg::CMD_NOP;
    end else begin
      link.cmd <= zq_pkg::CMD_NOP;
      if (state_next == ST_PRE) begin
        link.cmd <= zq_pkg::CMD_PREA;
      end else if (state_next == ST_ISSUE) begin
        link.cmd <= pend_long_reg ? zq_pkg::CMD_ZQCL : zq_pkg::CMD_ZQCS;
      end else if (state_reg == ST_IDLE && state_next == ST_SREF) begin
        link.cmd <= zq_pkg::CMD_SRE;
      end else if (state_reg == ST_SREF && state_next == ST_XS) begin
        link.cmd <= zq_pkg::CMD_SRX;
      end
    end
  end

  // cke low only in self refresh and under reset, high through every calibration
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link.cke <= 1'b0;
    end else begin
      link.cke <= (state_next != ST_SREF);
    end
  end

  // termination and data drive forced off while quiet
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link.odt   <= 1'b0;
      link.dq_oe <= 1'b0;
    end else begin
      link.odt   <= odt_req && !quiet && state_next != ST_ISSUE &&
                    state_next != ST_PRE && state_next == ST_IDLE;
      link.dq_oe <= dq_drive_req && state_next == ST_IDLE;
    end
  end

  // status outputs for the user and peers sharing the resistor
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cal_active <= 1'b0;
      busy       <= 1'b0;
    end else begin
      cal_active <= (state_next == ST_ISSUE) || (state_next == ST_WAIT);
      busy       <= (state_next != ST_IDLE);
    end
  end

endmodule

//--- zq_properties.sv
// link checker: quiet windows, pin states and command spacing on the zq link
// assumes instantiation beside the link, with the window counts of both ends
`timescale 1ns/1ps
module zq_properties #(
  parameter int TZQINIT = 16,
  parameter int TZQOPER = 8,
  parameter int TZQCS   = 4,
  parameter int TXS     = 8,
  parameter int TRP     = 1
) (
  input wire logic         clock,  // system clock
  input wire logic         nrst,   // async reset, active low
  input wire logic         cke,    // clock enable
  input wire zq_pkg::cmd_e cmd,    // link command
  input wire logic         odt,    // termination control
  input wire logic         dq_oe   // controller data drive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic [9:0]   gap_reg;    // cycles since the last command
  zq_pkg::cmd_e last_reg;   // last command seen
  logic         first_reg;  // no long calibration yet
  logic         init_reg;   // last command was the first long

  // track the last command and how long ago it was
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 10'h000;
      last_reg <= zq_pkg::CMD_NOP;
      first_reg <= 1'b1;
      init_reg <= 1'b0;
    end else if (cmd != zq_pkg::CMD_NOP) begin
      gap_reg <= 10'h001;
      last_reg <= cmd;
      init_reg <= first_reg && (cmd == zq_pkg::CMD_ZQCL);
      if (cmd == zq_pkg::CMD_ZQCL) first_reg <= 1'b0;
    end else if (gap_reg != 10'h3ff) begin
      gap_reg <= gap_reg + 10'h001;
    end
  end

  sequence s_zq;
    cmd inside {zq_pkg::CMD_ZQCL, zq_pkg::CMD_ZQCS};
  endsequence
  sequence s_next;
    cmd != zq_pkg::CMD_NOP;
  endsequence

  property p_init;  s_next ##0 (last_reg == zq_pkg::CMD_ZQCL && init_reg) |-> gap_reg >= TZQINIT;
  endproperty
  property p_oper;  s_next ##0 (last_reg == zq_pkg::CMD_ZQCL && !init_reg) |-> gap_reg >= TZQOPER;
  endproperty
  property p_short; s_next ##0 (last_reg == zq_pkg::CMD_ZQCS) |-> gap_reg >= TZQCS;
  endproperty
  property p_txs;   s_zq ##0 (last_reg == zq_pkg::CMD_SRX) |-> gap_reg >= TXS;
  endproperty
  property p_trp;   s_zq ##0 (last_reg == zq_pkg::CMD_PREA) |-> gap_reg >= TRP;
  endproperty
  property p_cke;   s_zq |-> cke [*4];
  endproperty
  property p_odt;   s_zq |-> !odt [*4];
  endproperty
  property p_dq;    s_zq |-> !dq_oe [*4];
  endproperty

  a_init:  assert property (p_init) else $error("first long window cut short");
  a_oper:  assert property (p_oper) else $error("long window cut short");
  a_short: assert property (p_short) else $error("short window cut short");
  a_txs:   assert property (p_txs) else $error("calibration too soon after exit");
  a_trp:   assert property (p_trp) else $error("calibration too soon after precharge");
  a_cke:   assert property (p_cke) else $error("clock enable low in calibration");
  a_odt:   assert property (p_odt) else $error("termination on in calibration");
  a_dq:    assert property (p_dq) else $error("data driven in calibration");
endmodule

//--- testbench.sv
// self-checking bench: controller and device joined by the zq link
// assumes short windows 16/8/4 on both ends and exit time 8 at the controller and checker
`timescale 1ns/1ps
module testbench;
  localparam int WI = 16;
  localparam int WO = 8;
  localparam int WS = 4;
  localparam int WX = 8;
  typedef struct {int w; logic up; logic lng;} note_s;

  logic        clock = 0, nrst = 0, zq_cmp_high = 0, zqcl_req = 0, zqcs_req = 0;
  logic        sre_req = 0, srx_req = 0, banks_open = 0, share_busy = 0;
  logic        odt_req = 0, dq_drive_req = 0;
  logic [5:0]  ron_code, rtt_code, prev_ron, prev_rtt;
  logic        zq_current_en, calibrating, cal_done, in_self_refresh;
  logic        cal_active, busy, long_done;
  int          miscompares = 0, n_tests = 0, cyc = 0, t0 = 0;
  bit          off_due = 0;
  logic [31:0] seed = 32'h51f2_9f42;
  note_s       notes[$];
  note_s       cur;

  zq_link_if link();

  always #20 clock = ~clock;

  zq_device #(.TZQINIT(WI), .TZQOPER(WO), .TZQCS(WS)) zq_device_inst (
    .clock(clock), .nrst(nrst), .link(link.dev), .zq_cmp_high(zq_cmp_high),
    .ron_code(ron_code), .rtt_code(rtt_code), .zq_current_en(zq_current_en),
    .calibrating(calibrating), .cal_done(cal_done), .in_self_refresh(in_self_refresh));
  zq_controller #(.TZQINIT(WI), .TZQOPER(WO), .TZQCS(WS), .TXS(WX), .TRP(zq_pkg::TRP_CYC))
  zq_controller_inst (
    .clock(clock), .nrst(nrst), .link(link.ctrl), .zqcl_req(zqcl_req), .zqcs_req(zqcs_req),
    .sre_req(sre_req), .srx_req(srx_req), .banks_open(banks_open), .share_busy(share_busy),
    .odt_req(odt_req), .dq_drive_req(dq_drive_req), .cal_active(cal_active), .busy(busy),
    .long_done(long_done));
  zq_properties #(.TZQINIT(WI), .TZQOPER(WO), .TZQCS(WS), .TXS(WX), .TRP(zq_pkg::TRP_CYC))
  zq_properties_inst (
    .clock(clock), .nrst(nrst), .cke(link.cke), .cmd(link.cmd), .odt(link.odt),
    .dq_oe(link.dq_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk_time(input string n, input int e, input int g);
    n_tests++;
    if (g != e) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic test_done();
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // random comparator level and pins, note the expectation, pulse the request
  task automatic req(input logic lng, input int w);
    logic [31:0] r;
    r = rnd();
    zq_cmp_high = r[0];
    odt_req = r[1];
    dq_drive_req = r[2];
    notes.push_back('{w, r[0], lng});
    zqcl_req = lng;
    zqcs_req = !lng;
    step(1);
    zqcl_req = 0;
    zqcs_req = 0;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      if (notes.size() == 0 && busy === 1'b0) break;
      step(1);
    end
    chk_flag("idle", 1'b0, busy);
  endtask

  // self refresh round trip, optionally with a request queued inside it
  task automatic sref(input logic with_req);
    sre_req = 1;
    step(1);
    sre_req = 0;
    step(3);
    chk_flag("in_self_refresh", 1'b1, in_self_refresh);
    if (with_req) req(0, WS);
    srx_req = 1;
    step(1);
    srx_req = 0;
    for (int i = 0; i < WX; i++) begin
      chk_flag("no_self_cal", 1'b0, calibrating);
      step(1);
    end
    chk_flag("sr_exit", 1'b0, in_self_refresh);
    wait_idle();
  endtask

  // watch transfers and compare them with the oldest note
  always @(negedge clock) begin
    if (!nrst) begin
      prev_ron = 6'h20;
      prev_rtt = 6'h20;
      off_due = 0;
    end else begin
      cyc++;
      if (off_due) chk_flag("current_off", 1'b0, zq_current_en);
      off_due = 0;
      if (link.cmd inside {zq_pkg::CMD_ZQCL, zq_pkg::CMD_ZQCS}) begin
        t0 = cyc;
        chk_flag("cal_active", 1'b1, cal_active);
      end
      if (cal_done === 1'b1) begin
        if (notes.size() == 0) begin
          chk_flag("unexpected_done", 1'b0, 1'b1);
        end else begin
          cur = notes.pop_front();
          // command registered one edge after it shows, transfer w edges later, pulse after
          chk_time("window", cur.w + 1, cyc - t0);
          chk_flag("ron_dir", cur.up, ron_code > (cur.lng ? 6'h20 : prev_ron));
          chk_flag("rtt_dir", cur.up, rtt_code > (cur.lng ? 6'h20 : prev_rtt));
          prev_ron = ron_code;
          prev_rtt = rtt_code;
          off_due = 1;
        end
      end
    end
  end

  // main sequence
  initial begin
    step(4);
    nrst = 1;
    step(1);
    req(1, WI);
    wait_idle();
    chk_flag("long_done", 1'b1, long_done);
    banks_open = 1;
    req(1, WO);
    wait_idle();
    banks_open = 0;
    repeat (4) begin
      req(0, WS);
      wait_idle();
    end
    share_busy = 1;
    req(0, WS);
    step(20);
    chk_flag("share_hold", 1'b0, cal_active);
    share_busy = 0;
    wait_idle();
    sref(0);
    sref(1);
    nrst = 0;
    step(2);
    nrst = 1;
    step(1);
    chk_flag("long_done_rst", 1'b0, long_done);
    req(1, WI);
    wait_idle();
    chk_time("notes_left", 0, notes.size());
    test_done();
  end

  // watchdog
  initial begin
    step(6000);
    miscompares++;
    test_done();
  end
endmodule
